// ---- src/svdc_pkg.sv ----
`default_nettype none
// ==========================================================================
// shared constants and types
package svdc_pkg;

  // ========================================================================
  // register bus
  localparam int         ADDR_W          = 3;
  localparam int         DATA_W          = 8;
  localparam logic [2:0] ADDR_CTRL       = 3'h0;
  localparam logic [2:0] ADDR_INTCTL     = 3'h1;
  localparam logic [2:0] ADDR_FLAGS      = 3'h2;
  localparam logic [2:0] ADDR_ENABLES    = 3'h3;
  localparam logic [2:0] ADDR_PRIORITY   = 3'h4;

  // ========================================================================
  // field positions
  localparam int         CTRL_DIR_BIT    = 7;
  localparam int         CTRL_UNUSED_BIT = 6;
  localparam int         CTRL_STABLE_BIT = 5;
  localparam int         CTRL_EN_BIT     = 4;
  localparam int         GLOBAL_IE_BIT   = 7;
  localparam int         PERIPH_IE_BIT   = 6;
  localparam int         DET_BIT         = 2;

  // ========================================================================
  // reset values and codes
  localparam logic [7:0] CTRL_RESET      = 8'h05;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [3:0] LEVEL_EXTERNAL  = 4'hf;

  // ========================================================================
  // timing
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         SETTLE_TIME_NS  = 20000;
  localparam int         SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         SETTLE_CNT_W    = 10;
  localparam logic [9:0] SETTLE_LAST     = 10'(SETTLE_CYCLES - 1);

  // ========================================================================
  // types
  typedef struct packed {
    logic       dir;
    logic       unused;
    logic       stable;
    logic       enable;
    logic [3:0] level;
  } svdc_ctrl_type;

  typedef struct packed {
    logic       enable;
    logic       ext_sel;
    logic [3:0] level;
  } svdc_afe_type;

  typedef enum logic [1:0] {
    SVDC_OFF    = 2'b00,
    SVDC_SETTLE = 2'b01,
    SVDC_READY  = 2'b11
  } svdc_state_type;

endpackage : svdc_pkg
`default_nettype wire

// ---- src/svdc_top.sv ----
`default_nettype none
module svdc_top
(
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // register port
  input  wire logic [svdc_pkg::ADDR_W-1:0] BUS_ADDR,
  input  wire logic [svdc_pkg::DATA_W-1:0] BUS_WDATA,
  input  wire logic                       BUS_WR,
  input  wire logic                       BUS_RD,
  output logic      [svdc_pkg::DATA_W-1:0] BUS_RDATA,
  // analog front end, asynchronous
  input  wire logic                       CMP_AT_OR_ABOVE,
  input  wire logic                       CMP_AT_OR_BELOW,
  input  wire logic                       REF_READY,
  output svdc_pkg::svdc_afe_type          AFE,
  // interrupt
  output logic                            IRQ,
  output logic                            WAKE,
  output logic                            IRQ_HIGH_PRIORITY
);
  import svdc_pkg::*;

  // ========================================================================
  // synchronisers
  logic [2:0]     sync_meta;
  logic [2:0]     sync_out;
  logic           above_s;
  logic           below_s;
  logic           ref_ok_s;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync_meta <= 3'h0;
      sync_out  <= 3'h0;
    end
    else
    begin
      sync_meta <= {REF_READY, CMP_AT_OR_BELOW, CMP_AT_OR_ABOVE};
      sync_out  <= sync_meta;
    end
  end

  assign above_s  = sync_out[0];
  assign below_s  = sync_out[1];
  assign ref_ok_s = sync_out[2];

  // ========================================================================
  // registers
  svdc_ctrl_type  ctrl;
  svdc_ctrl_type  next_ctrl;
  logic [1:0]     intctl;
  logic [1:0]     next_intctl;
  logic           flag;
  logic           next_flag;
  logic           det_ie;
  logic           next_det_ie;
  logic           det_ip;
  logic           next_det_ip;
  logic [7:0]     rdata;
  logic [7:0]     next_rdata;
  logic           stable;
  logic           trip;
  logic           wr_ctrl;
  logic           wr_flags;

  assign wr_ctrl  = BUS_WR && (BUS_ADDR == ADDR_CTRL);
  assign wr_flags = BUS_WR && (BUS_ADDR == ADDR_FLAGS);

  // direction picks which comparator side counts
  // both comparator outputs include the equal point
  assign trip = ctrl.dir ? above_s : below_s;

  always_comb
  begin
    next_ctrl    = ctrl;
    next_intctl  = intctl;
    next_det_ie  = det_ie;
    next_det_ip  = det_ip;
    next_rdata   = 8'h00;
    // stable is not writable, bit 6 stays zero
    if (wr_ctrl)
    begin
      next_ctrl.dir    = BUS_WDATA[CTRL_DIR_BIT];
      next_ctrl.enable = BUS_WDATA[CTRL_EN_BIT];
      next_ctrl.level  = BUS_WDATA[3:0];
    end
    next_ctrl.unused = 1'b0;
    next_ctrl.stable = stable;
    if (BUS_WR && (BUS_ADDR == ADDR_INTCTL))
    begin
      next_intctl = {BUS_WDATA[GLOBAL_IE_BIT], BUS_WDATA[PERIPH_IE_BIT]};
    end
    if (BUS_WR && (BUS_ADDR == ADDR_ENABLES))
    begin
      next_det_ie = BUS_WDATA[DET_BIT];
    end
    if (BUS_WR && (BUS_ADDR == ADDR_PRIORITY))
    begin
      next_det_ip = BUS_WDATA[DET_BIT];
    end
    // set wins over a write-one clear
    next_flag = (stable && trip) || (flag && !(wr_flags && BUS_WDATA[DET_BIT]));
    if (BUS_RD)
    begin
      unique case (BUS_ADDR)
        ADDR_CTRL:     next_rdata = ctrl;
        ADDR_INTCTL:   next_rdata = {intctl, 6'h00};
        ADDR_FLAGS:    next_rdata = {5'h00, flag, 2'h0};
        ADDR_ENABLES:  next_rdata = {5'h00, det_ie, 2'h0};
        ADDR_PRIORITY: next_rdata = {5'h00, det_ip, 2'h0};
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // every register returns to its reset value
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl   <= CTRL_RESET;
      intctl <= 2'h0;
      flag   <= 1'b0;
      det_ie <= 1'b0;
      det_ip <= 1'b0;
      rdata  <= REG_RESET;
    end
    else
    begin
      ctrl   <= next_ctrl;
      intctl <= next_intctl;
      flag   <= next_flag;
      det_ie <= next_det_ie;
      det_ip <= next_det_ip;
      rdata  <= next_rdata;
    end
  end

  // ========================================================================
  // settle sequencer
  svdc_state_type         state;
  svdc_state_type         next_state;
  logic [SETTLE_CNT_W-1:0] settle_cnt;
  logic [SETTLE_CNT_W-1:0] next_settle_cnt;

  // fixed count, then waits for reference ready, independent of software; missed excursions accepted
  always_comb
  begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    unique case (state)
      SVDC_OFF:
      begin
        next_settle_cnt = '0;
        if (ctrl.enable)
        begin
          next_state = SVDC_SETTLE;
        end
      end
      SVDC_SETTLE:
      begin
        if (settle_cnt != SETTLE_LAST)
        begin
          next_settle_cnt = settle_cnt + 10'h001;
        end
        else if (ref_ok_s)
        begin
          next_state = SVDC_READY;
        end
        if (!ctrl.enable)
        begin
          next_state = SVDC_OFF;
        end
      end
      SVDC_READY:
      begin
        if (!ctrl.enable)
        begin
          next_state = SVDC_OFF;
        end
      end
      default:
      begin
        next_state = SVDC_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state      <= SVDC_OFF;
      settle_cnt <= '0;
    end
    else
    begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  // stable only in the settled state
  assign stable = (state == SVDC_READY) && ctrl.enable;

  // ========================================================================
  // outputs
  assign BUS_RDATA         = rdata;
  assign AFE.enable        = ctrl.enable;
  // all-ones level selects the external pin
  assign AFE.ext_sel       = (ctrl.level == LEVEL_EXTERNAL);
  assign AFE.level         = ctrl.level;
  // wake needs no global enable, so sleep exits even when masked globally
  assign WAKE              = flag && det_ie;
  // vectoring also needs the global enable
  assign IRQ               = WAKE && intctl[1];
  assign IRQ_HIGH_PRIORITY = IRQ && det_ip;

  // ========================================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_stable_after_settle: assert property
    ($rose(ctrl.stable) |-> $past(settle_cnt) == SETTLE_LAST)
    else $error("stable rose before settle count ran out");

  chk_flag_needs_stable: assert property
    ($rose(flag) |-> $past(stable, 1))
    else $error("flag set while not stable");

  chk_fall_trip: assert property
    (stable && !ctrl.dir && below_s |=> flag)
    else $error("fall trip did not set flag");

  chk_rise_trip: assert property
    (stable && ctrl.dir && above_s |=> flag)
    else $error("rise trip did not set flag");

  chk_level_write: assert property
    (wr_ctrl |=> AFE.level == $past(BUS_WDATA[3:0]))
    else $error("trip level not taken from write");

  chk_external_route: assert property
    (wr_ctrl && BUS_WDATA[3:0] == 4'hf |=> AFE.ext_sel)
    else $error("external input not routed");

  chk_irq_gating: assert property
    (IRQ |-> flag && det_ie && intctl[1])
    else $error("irq without both enables");

  chk_settle_time: assert property
    ($rose(state == SVDC_SETTLE) |-> !stable [*8])
    else $error("stable too early after enable");

  chk_flag_persists: assert property
    (stable && trip && wr_flags && BUS_WDATA[DET_BIT] |=> flag)
    else $error("flag lost while condition holds");

  chk_wake_masked: assert property
    (flag && det_ie && !intctl[1] |-> WAKE && !IRQ)
    else $error("wake wrong with global disable");

  chk_reset_state: assert property
    ($past(RST) |-> ctrl == CTRL_RESET && !flag && !IRQ)
    else $error("register not at reset value");

  chk_ctrl_readback: assert property
    (BUS_RD && BUS_ADDR == ADDR_CTRL |=> BUS_RDATA[CTRL_UNUSED_BIT] == 1'b0
      && BUS_RDATA[CTRL_STABLE_BIT] == $past(ctrl.stable))
    else $error("control readback wrong");

  cov_reach_stable:   cover property ($rose(stable));
  cov_fall_event:     cover property (stable && !ctrl.dir ##1 $rose(flag));
  cov_rise_event:     cover property (stable && ctrl.dir ##1 $rose(flag));
  cov_irq_raised:     cover property ($rose(IRQ));
  cov_external_level: cover property (AFE.ext_sel && $rose(flag));

endmodule : svdc_top
`default_nettype wire

// ---- bench/svdc_top_tb_top.sv ----
`default_nettype none
// ==========================================================================
// compare helper, counts every check
`define SVDC_CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("FAIL %s expected %h seen %h", what, exp, got); \
    end \
  end

module svdc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import svdc_pkg::*;

  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic              cmp_above;
  logic              cmp_below;
  logic              ref_ready;
  svdc_afe_type      afe;
  logic              irq;
  logic              wake;
  logic              irq_hi;
  int                fails;
  int                checks_done;

  svdc_top u_dut
  (
    .CLK               (clk),
    .RST               (rst),
    .BUS_ADDR          (bus_addr),
    .BUS_WDATA         (bus_wdata),
    .BUS_WR            (bus_wr),
    .BUS_RD            (bus_rd),
    .BUS_RDATA         (bus_rdata),
    .CMP_AT_OR_ABOVE   (cmp_above),
    .CMP_AT_OR_BELOW   (cmp_below),
    .REF_READY         (ref_ready),
    .AFE               (afe),
    .IRQ               (irq),
    .WAKE              (wake),
    .IRQ_HIGH_PRIORITY (irq_hi)
  );

  // ========================================================================
  // bus tasks
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_check(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    `SVDC_CHK(what, exp, bus_rdata)
  endtask : reg_check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic reset_checks();
    reg_check(ADDR_CTRL, CTRL_RESET, "control");
    for (int i = 1; i < 6; i++)
    begin
      reg_check(3'(i), REG_RESET, "reg after reset");
    end
    `SVDC_CHK("afe after reset", 6'h05, afe)
    `SVDC_CHK("irq after reset", 3'h0, {irq, wake, irq_hi})
  endtask : reset_checks

  task automatic end_of_test();
    if (fails == 0 && checks_done > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // run needs about 700 cycles
  initial
  begin
    #800000;
    fails++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    bus_addr = '0;
    bus_wdata = '0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    cmp_above = 1'b0;
    cmp_below = 1'b0;
    ref_ready = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    reset_checks();
    // ======================================================================
    // level select and external input routing
    for (int i = 0; i < 16; i++)
    begin
      reg_write(ADDR_CTRL, {4'h0, 4'(i)});
      wait_cyc(1);
      `SVDC_CHK("afe level", 4'(i), afe.level)
      `SVDC_CHK("afe ext sel", (i == 15), afe.ext_sel)
    end
    // stable and unused bits ignore writes; reference not ready yet
    reg_write(ADDR_CTRL, 8'hff);
    reg_check(ADDR_CTRL, 8'h9f, "control layout");
    `SVDC_CHK("afe enable", 1'b1, afe.enable)
    reg_write(ADDR_CTRL, 8'h00);
    // ======================================================================
    // settling: trips inside the interval are lost
    ref_ready <= 1'b1;
    reg_write(ADDR_CTRL, 8'h14);
    cmp_below <= 1'b1;
    wait_cyc(400);
    reg_check(ADDR_CTRL, 8'h14, "stable early");
    reg_check(ADDR_FLAGS, 8'h00, "flag in settle");
    cmp_below <= 1'b0;
    wait_cyc(120);
    reg_check(ADDR_CTRL, 8'h34, "stable late");
    reg_check(ADDR_FLAGS, 8'h00, "flag after settle");
    // ======================================================================
    // fall mode events, gating and priority
    reg_write(ADDR_FLAGS, 8'h04);
    reg_write(ADDR_ENABLES, 8'h04);
    cmp_above <= 1'b1;
    wait_cyc(5);
    `SVDC_CHK("wake on rise", 1'b0, wake)
    cmp_above <= 1'b0;
    cmp_below <= 1'b1;
    wait_cyc(1);
    `SVDC_CHK("wake too early", 1'b0, wake)
    wait_cyc(3);
    `SVDC_CHK("wake on fall", 1'b1, wake)
    `SVDC_CHK("irq no global", 1'b0, irq)
    // peripheral enable is stored only, it must not change the irq
    reg_write(ADDR_INTCTL, 8'hff);
    wait_cyc(1);
    `SVDC_CHK("irq global", 2'b10, {irq, irq_hi})
    reg_check(ADDR_INTCTL, 8'hc0, "intctl readback");
    reg_write(ADDR_PRIORITY, 8'h04);
    wait_cyc(1);
    `SVDC_CHK("irq high prio", 1'b1, irq_hi)
    reg_write(ADDR_FLAGS, 8'h04);
    reg_check(ADDR_FLAGS, 8'h04, "flag persists");
    cmp_below <= 1'b0;
    wait_cyc(4);
    reg_write(ADDR_FLAGS, 8'h04);
    reg_check(ADDR_FLAGS, 8'h00, "flag cleared");
    `SVDC_CHK("irq cleared", 1'b0, irq)
    // ======================================================================
    // rise mode and masking
    reg_write(ADDR_CTRL, 8'h94);
    cmp_below <= 1'b1;
    wait_cyc(5);
    reg_check(ADDR_FLAGS, 8'h00, "fall in rise mode");
    reg_check(ADDR_CTRL, 8'hb4, "control rise");
    cmp_below <= 1'b0;
    cmp_above <= 1'b1;
    wait_cyc(5);
    `SVDC_CHK("irq on rise", 1'b1, irq)
    reg_write(ADDR_ENABLES, 8'h00);
    wait_cyc(1);
    `SVDC_CHK("masked", 2'b00, {irq, wake})
    reg_check(ADDR_FLAGS, 8'h04, "masked flag");
    cmp_above <= 1'b0;
    wait_cyc(4);
    reg_write(ADDR_FLAGS, 8'h04);
    // ======================================================================
    // disable drops stable and blocks events
    reg_write(ADDR_CTRL, 8'h84);
    wait_cyc(1);
    `SVDC_CHK("afe off", 1'b0, afe.enable)
    reg_check(ADDR_CTRL, 8'h84, "stable off");
    cmp_above <= 1'b1;
    wait_cyc(5);
    reg_check(ADDR_FLAGS, 8'h00, "flag disabled");
    cmp_above <= 1'b0;
    // ======================================================================
    // reset in mid-run with state loaded
    reg_write(ADDR_ENABLES, 8'h04);
    reg_write(ADDR_CTRL, 8'h9f);
    rst <= 1'b1;
    wait_cyc(2);
    rst <= 1'b0;
    reset_checks();
    end_of_test();
  end

endmodule : svdc_top_tb_top
`undef SVDC_CHK
`default_nettype wire
